// *** adc_window_defs.svh ***
`ifndef ADC_WINDOW_DEFS_SVH
`define ADC_WINDOW_DEFS_SVH
// Register offsets
`define OFS_BUF_CTRL 8'h23
`define OFS_RES_HI 8'h24
`define OFS_RES_LO 8'h25
`define OFS_SCHMITT_HI 8'h26
`define OFS_SCHMITT_LO 8'h27
`define OFS_UPPER_HI 8'h28
`define OFS_UPPER_LO 8'h29
`define OFS_LOWER_HI 8'h2a
`define OFS_LOWER_LO 8'h2b
`define OFS_WSTAT_HI 8'h2c
`define OFS_WSTAT_LO 8'h2d
`define OFS_WEN_HI 8'h2e
`define OFS_WEN_LO 8'h2f
`define OFS_MODE_CTRL 8'h30
`define OFS_WSUMMARY 8'h31
// Field positions
`define BIT_BUF_ENABLE 7
`define BIT_OVERRUN 6
`define BIT_CONT 0
`define BIT_SCAN 1
`define BIT_RIGHT_JUST 2
`define BIT_WIN_IE 3
`define BIT_SUMMARY 0
// Reset values and slot count
`define RST_UPPER_HI 8'hff
`define RST_UPPER_LO 2'h3
`define RST_ZERO8 8'h00
`define SLOTS 10
`endif

// *** adc_window_pkg.sv ***
`default_nettype none
package adc_window_pkg;
  // One converted sample from the analog core
  typedef struct packed {
    logic valid;
    logic [3:0] slot;
    logic [9:0] value;
  } sample_type;
  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_type;
endpackage
`default_nettype wire

// *** adc_result_and_window_watch.sv ***
// Contract
// RQ1: Buffered continuous needs buffer enable and continuous
// RQ2: Buffer enabled sends results to slot buffers
// RQ3: Overrun flag sets, cleared by writing zero
// RQ4: Unbuffered results land in read-only result registers
// RQ5: Left justify: eight MSBs in high
// RQ6: Left justify: remaining bits low, rest zero
// RQ7: Right justify: eight LSBs in low
// RQ8: Right justify: upper bits high, rest zero
// RQ9: Software reads high first when left
// RQ10: Software reads low first when right
// RQ11: Sixteen Schmitt disable bits, one per channel
// RQ12: Upper limit ten bits, resets all ones
// RQ13: Lower limit ten bits, resets to zero
// RQ14: Ten slot event flags, cleared by zero
// RQ15: Ten slot enables gate the window check
// RQ16: Software keeps reserved bits zero
// RQ17: Reduced variant omits buffer and window registers
// RQ18: Justify bit zero left, one right
// RQ19: Any event sets summary, optional interrupt
// RQ20: Event means above upper or below lower
// RQ21: Overrun when unread slot is overwritten
`timescale 1ns/100ps
`default_nettype none
`include "adc_window_defs.svh"
module adc_result_and_window_watch #(
  parameter bit FULL_VARIANT = 1'b1 // Zero builds the reduced variant
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire adc_window_pkg::bus_req_type busReq,
  output logic [7:0] rdData,
  input wire adc_window_pkg::sample_type sample,
  input wire logic slotRead,
  input wire logic [3:0] slotReadIdx,
  output logic bufferedMode,
  output logic toBuffer,
  output logic [15:0] schmittDisable,
  output logic windowIrq
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic bufEnable_q; // Route results into slot buffers
  logic overrun_q; // Sticky overrun
  logic cont_q; // Continuous conversion mode
  logic scan_q; // Scan mode
  logic rightJust_q; // Justification select
  logic winIe_q; // Window interrupt enable
  logic summary_q; // Summary window flag
  logic [9:0] result_q; // Last unbuffered result
  logic [15:0] schmitt_q; // Schmitt disable bits
  logic [9:0] upper_q; // Upper window limit
  logic [9:0] lower_q; // Lower window limit
  logic [9:0] wstat_q; // Per-slot event flags
  logic [9:0] wen_q; // Per-slot check enables
  logic [9:0] unread_q; // Slot written and not yet read
  logic [7:0] rdData_q; // Registered read data
  logic [7:0] resHi; // Justified high byte
  logic [7:0] resLo; // Justified low byte
  logic checkMode; // Window check allowed
  logic [9:0] slotHit; // One-hot slot of current sample
  logic [9:0] slotEvent; // Window events this cycle
  logic [9:0] slotRd; // One-hot slot read strobe
  logic newOverrun; // Overwrite of unread slot
  logic [9:0] wstatKeep; // Event flags kept by this cycle's writes

  // Write decode helper
  function automatic logic wrAt(input logic [7:0] ofs);
    wrAt = busReq.wr && (busReq.addr == ofs);
  endfunction

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign bufferedMode = bufEnable_q && cont_q; // RQ1
  assign toBuffer = bufEnable_q; // RQ2
  assign checkMode = bufferedMode || scan_q;
  assign schmittDisable = schmitt_q; // RQ11

  // Per slot event and strobe decode
  genvar gi;
  generate
    for (gi = 0; gi < `SLOTS; gi++) begin : gSlot
      assign slotHit[gi] = sample.valid && (sample.slot == 4'(gi));
      assign slotRd[gi] = slotRead && (slotReadIdx == 4'(gi));
      // Outside the window in an enabled slot
      assign slotEvent[gi] = slotHit[gi] && checkMode && wen_q[gi] &&
        ((sample.value > upper_q) || (sample.value < lower_q)); // RQ15 RQ20
      // An enabled out-of-window sample raises the flag of its own slot
      property p_slotFlag;
        @(posedge mclk) disable iff (!rst_b)
          slotHit[gi] && wen_q[gi] && checkMode &&
          ((sample.value > upper_q) || (sample.value < lower_q)) |=> wstat_q[gi];
      endproperty
      a_slotFlag: assert property (p_slotFlag) else $error("slot flag missing"); // RQ20
    end
  endgenerate

  assign newOverrun = toBuffer && |(slotHit & unread_q & ~slotRd); // RQ21

  // ----------------------------------------
  // Control register, modes
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bufEnable_q <= 1'b0;
      cont_q <= 1'b0;
      scan_q <= 1'b0;
      rightJust_q <= 1'b0;
      winIe_q <= 1'b0;
    end else begin
      // Reduced variant keeps the buffer off
      if (wrAt(`OFS_BUF_CTRL) && FULL_VARIANT) begin // RQ17
        bufEnable_q <= busReq.wdata[`BIT_BUF_ENABLE];
      end
      if (wrAt(`OFS_MODE_CTRL)) begin
        cont_q <= busReq.wdata[`BIT_CONT];
        scan_q <= busReq.wdata[`BIT_SCAN] && FULL_VARIANT;
        rightJust_q <= busReq.wdata[`BIT_RIGHT_JUST]; // RQ18
        winIe_q <= busReq.wdata[`BIT_WIN_IE];
      end
    end
  end

  // Overrun flag; a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      overrun_q <= 1'b0;
    end else if (newOverrun && FULL_VARIANT) begin
      overrun_q <= 1'b1; // RQ3
    end else if (wrAt(`OFS_BUF_CTRL) && !busReq.wdata[`BIT_OVERRUN]) begin
      overrun_q <= 1'b0; // RQ3
    end
  end

  // Unread tracking per slot
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      unread_q <= '0;
    end else if (toBuffer) begin
      unread_q <= (unread_q & ~slotRd) | slotHit;
    end else begin
      unread_q <= unread_q & ~slotRd;
    end
  end

  // ----------------------------------------
  // Result register
  // ----------------------------------------
  // Only unbuffered conversions update it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= '0;
    end else if (sample.valid && !toBuffer) begin
      result_q <= sample.value; // RQ4
    end
  end

  // Justification of the read view
  always_comb begin
    if (rightJust_q) begin
      resLo = result_q[7:0]; // RQ7
      resHi = {6'h00, result_q[9:8]}; // RQ8
    end else begin
      resHi = result_q[9:2]; // RQ5
      resLo = {6'h00, result_q[1:0]}; // RQ6
    end
  end

  // ----------------------------------------
  // Schmitt and limit registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      schmitt_q <= '0;
    end else begin
      if (wrAt(`OFS_SCHMITT_HI)) schmitt_q[15:8] <= busReq.wdata; // RQ11
      if (wrAt(`OFS_SCHMITT_LO)) schmitt_q[7:0] <= busReq.wdata; // RQ11
    end
  end

  // Limits are absent in the reduced variant
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      upper_q <= {`RST_UPPER_HI, `RST_UPPER_LO}; // RQ12
      lower_q <= '0; // RQ13
    end else if (FULL_VARIANT) begin
      if (wrAt(`OFS_UPPER_HI)) upper_q[9:2] <= busReq.wdata; // RQ12
      if (wrAt(`OFS_UPPER_LO)) upper_q[1:0] <= busReq.wdata[1:0]; // RQ12
      if (wrAt(`OFS_LOWER_HI)) lower_q[9:2] <= busReq.wdata; // RQ13
      if (wrAt(`OFS_LOWER_LO)) lower_q[1:0] <= busReq.wdata[1:0]; // RQ13
    end
  end

  // Slot enables
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wen_q <= '0;
    end else if (FULL_VARIANT) begin
      if (wrAt(`OFS_WEN_HI)) wen_q[9:8] <= busReq.wdata[1:0]; // RQ15
      if (wrAt(`OFS_WEN_LO)) wen_q[7:0] <= busReq.wdata; // RQ15
    end
  end

  // ----------------------------------------
  // Window event flags
  // ----------------------------------------
  // Write zero clears; a new event in the same cycle wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wstat_q <= '0;
    end else begin
      wstat_q <= (wstat_q & wstatKeep) | (slotEvent & {10{FULL_VARIANT}}); // RQ14
    end
  end

  // Flags that survive this cycle's writes; a written zero drops its flag
  always_comb begin
    wstatKeep = '1;
    if (wrAt(`OFS_WSTAT_HI)) wstatKeep[9:8] = busReq.wdata[1:0]; // RQ14
    if (wrAt(`OFS_WSTAT_LO)) wstatKeep[7:0] = busReq.wdata; // RQ14
  end

  // Summary flag and interrupt request
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      summary_q <= 1'b0;
    end else if (|slotEvent && FULL_VARIANT) begin
      summary_q <= 1'b1; // RQ19
    end else if (wrAt(`OFS_WSUMMARY) && !busReq.wdata[`BIT_SUMMARY]) begin
      summary_q <= 1'b0;
    end
  end

  assign windowIrq = summary_q && winIe_q; // RQ19

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Unmapped and omitted registers read zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_q <= '0;
    end else if (busReq.rd) begin
      case (busReq.addr)
        `OFS_BUF_CTRL: rdData_q <= FULL_VARIANT ? {bufEnable_q, overrun_q, 6'h00} : 8'h00;
        `OFS_RES_HI: rdData_q <= resHi;
        `OFS_RES_LO: rdData_q <= resLo;
        `OFS_SCHMITT_HI: rdData_q <= schmitt_q[15:8];
        `OFS_SCHMITT_LO: rdData_q <= schmitt_q[7:0];
        `OFS_UPPER_HI: rdData_q <= FULL_VARIANT ? upper_q[9:2] : 8'h00;
        `OFS_UPPER_LO: rdData_q <= FULL_VARIANT ? {6'h00, upper_q[1:0]} : 8'h00;
        `OFS_LOWER_HI: rdData_q <= lower_q[9:2];
        `OFS_LOWER_LO: rdData_q <= {6'h00, lower_q[1:0]};
        `OFS_WSTAT_HI: rdData_q <= {6'h00, wstat_q[9:8]};
        `OFS_WSTAT_LO: rdData_q <= wstat_q[7:0];
        `OFS_WEN_HI: rdData_q <= {6'h00, wen_q[9:8]};
        `OFS_WEN_LO: rdData_q <= wen_q[7:0];
        `OFS_MODE_CTRL: rdData_q <= {4'h0, winIe_q, rightJust_q, scan_q, cont_q};
        `OFS_WSUMMARY: rdData_q <= {7'h00, summary_q};
        default: rdData_q <= 8'h00;
      endcase
    end else begin
      rdData_q <= 8'h00;
    end
  end

  assign rdData = rdData_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_overrunSticky;
    @(posedge mclk) disable iff (!rst_b)
      overrun_q && !(wrAt(`OFS_BUF_CTRL) && !busReq.wdata[`BIT_OVERRUN]) |=> overrun_q;
  endproperty
  a_overrunSticky: assert property (p_overrunSticky) else $error("overrun lost"); // RQ3

  property p_overrunSet;
    @(posedge mclk) disable iff (!rst_b) newOverrun && FULL_VARIANT |=> overrun_q;
  endproperty
  a_overrunSet: assert property (p_overrunSet) else $error("overrun not set"); // RQ21

  property p_eventSets;
    @(posedge mclk) disable iff (!rst_b) |slotEvent |=> (wstat_q != 10'h000) && summary_q;
  endproperty
  a_eventSets: assert property (p_eventSets) else $error("event flag missing"); // RQ14

  property p_noCheckDisabled;
    @(posedge mclk) disable iff (!rst_b) |(slotEvent & ~wen_q) == 1'b0;
  endproperty
  a_noCheckDisabled: assert property (p_noCheckDisabled) else $error("disabled slot checked"); // RQ15

  property p_resultKept;
    @(posedge mclk) disable iff (!rst_b) sample.valid && toBuffer |=> $stable(result_q);
  endproperty
  a_resultKept: assert property (p_resultKept) else $error("result overwritten"); // RQ2

  property p_resultLoad;
    @(posedge mclk) disable iff (!rst_b)
      sample.valid && !toBuffer |=> result_q == $past(sample.value);
  endproperty
  a_resultLoad: assert property (p_resultLoad) else $error("result not loaded"); // RQ4

  property p_leftRead;
    @(posedge mclk) disable iff (!rst_b)
      busReq.rd && busReq.addr == `OFS_RES_LO && !rightJust_q |=> rdData[7:2] == 6'h00;
  endproperty
  a_leftRead: assert property (p_leftRead) else $error("left low not padded"); // RQ6

  property p_rightRead;
    @(posedge mclk) disable iff (!rst_b)
      busReq.rd && busReq.addr == `OFS_RES_HI && rightJust_q |=> rdData[7:2] == 6'h00;
  endproperty
  a_rightRead: assert property (p_rightRead) else $error("right high not padded"); // RQ8

  property p_bufMode;
    @(posedge mclk) disable iff (!rst_b)
      wrAt(`OFS_MODE_CTRL) && busReq.wdata[`BIT_CONT] && bufEnable_q |=> bufferedMode;
  endproperty
  a_bufMode: assert property (p_bufMode) else $error("buffered mode wrong"); // RQ1

  property p_leftHigh;
    @(posedge mclk) disable iff (!rst_b)
      busReq.rd && busReq.addr == `OFS_RES_HI && !rightJust_q |=> rdData == $past(result_q[9:2]);
  endproperty
  a_leftHigh: assert property (p_leftHigh) else $error("left high byte wrong"); // RQ5

  property p_rightLow;
    @(posedge mclk) disable iff (!rst_b)
      busReq.rd && busReq.addr == `OFS_RES_LO && rightJust_q |=> rdData == $past(result_q[7:0]);
  endproperty
  a_rightLow: assert property (p_rightLow) else $error("right low byte wrong"); // RQ7

  // Pins follow the register from the cycle after the write
  property p_schmittPins;
    @(posedge mclk) disable iff (!rst_b)
      wrAt(`OFS_SCHMITT_LO) |=> schmittDisable[7:0] == $past(busReq.wdata);
  endproperty
  a_schmittPins: assert property (p_schmittPins) else $error("schmitt pins stale"); // RQ11

  property p_upperWrite;
    @(posedge mclk) disable iff (!rst_b)
      FULL_VARIANT && wrAt(`OFS_UPPER_HI) |=> upper_q[9:2] == $past(busReq.wdata);
  endproperty
  a_upperWrite: assert property (p_upperWrite) else $error("upper limit not written"); // RQ12

  // Omitted registers must look empty in the reduced build
  property p_reducedRead;
    @(posedge mclk) disable iff (!rst_b)
      !FULL_VARIANT && busReq.rd &&
      (busReq.addr inside {`OFS_BUF_CTRL, `OFS_UPPER_HI, `OFS_UPPER_LO}) |=> rdData == 8'h00;
  endproperty
  a_reducedRead: assert property (p_reducedRead) else $error("omitted register readable"); // RQ17

  // A sample inside the window never counts as an event
  property p_noEventInside;
    @(posedge mclk) disable iff (!rst_b)
      (sample.value <= upper_q) && (sample.value >= lower_q) |-> slotEvent == 10'h000;
  endproperty
  a_noEventInside: assert property (p_noEventInside) else $error("event inside window"); // RQ20

  property p_irqFollows;
    @(posedge mclk) disable iff (!rst_b)
      summary_q && wrAt(`OFS_MODE_CTRL) && busReq.wdata[`BIT_WIN_IE] |=> windowIrq;
  endproperty
  a_irqFollows: assert property (p_irqFollows) else $error("window irq not raised"); // RQ19

  property p_overrunClear;
    @(posedge mclk) disable iff (!rst_b)
      wrAt(`OFS_BUF_CTRL) && !busReq.wdata[`BIT_OVERRUN] && !newOverrun |=> !overrun_q;
  endproperty
  a_overrunClear: assert property (p_overrunClear) else $error("overrun not cleared"); // RQ3

  // Zeros written clear their flags unless an event hits them at once
  property p_flagClear;
    @(posedge mclk) disable iff (!rst_b)
      wrAt(`OFS_WSTAT_LO) |=>
      (wstat_q[7:0] & ~$past(busReq.wdata) & ~$past(slotEvent[7:0])) == 8'h00;
  endproperty
  a_flagClear: assert property (p_flagClear) else $error("event flag not cleared"); // RQ14

endmodule
`default_nettype wire

// *** analog_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Converter core stand-in: samples and slot reads
// ----------------------------------------
module analog_core_model (
  input wire logic mclk,
  output var adc_window_pkg::sample_type sample,
  output var logic slotRead,
  output var logic [3:0] slotReadIdx
);
  // Quiet at time zero
  initial begin
    sample = '0;
    slotRead = 1'b0;
    slotReadIdx = 4'h0;
  end
  // One result after lag cycles; idle lines show the inverse so stale data never matches
  task automatic convert(input logic [3:0] slot, input logic [9:0] value, input int lag);
    repeat (lag) @(posedge mclk);
    sample <= '{valid: 1'b1, slot: slot, value: value};
    @(posedge mclk);
    sample <= '{valid: 1'b0, slot: ~slot, value: ~value};
  endtask
  // Software fetched one buffer slot
  task automatic fetch(input logic [3:0] idx);
    @(posedge mclk);
    slotRead <= 1'b1;
    slotReadIdx <= idx;
    @(posedge mclk);
    slotRead <= 1'b0;
    slotReadIdx <= ~idx;
  endtask
endmodule
`default_nettype wire

// *** adc_result_and_window_watch_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_result_and_window_watch_tb;
  // ----------------------------------------
  // Nets and bookkeeping
  // ----------------------------------------
  typedef struct {
    logic [7:0] exp;
    string what;
  } note_type;
  logic mclk; // 20 MHz clock
  logic rst_b; // Reset, active low
  adc_window_pkg::bus_req_type busReq; // Register bus
  adc_window_pkg::sample_type sample; // From core model
  logic [7:0] rdData;
  logic slotRead;
  logic [3:0] slotReadIdx;
  logic bufferedMode;
  logic toBuffer;
  logic windowIrq;
  logic [15:0] schmittDisable;
  note_type noteQ[$]; // Expected read data, oldest first
  note_type cur;
  logic rdSeen = 1'b0; // Read strobe taken at last edge
  int errCount;
  int nChecks;
  logic [9:0] val;
  logic [7:0] rdAddr = 8'h00; // Address of the read taken at last edge
  logic [7:0] redRdData; // Reduced variant read data
  logic redToBuffer; // Reduced variant buffer routing
  logic redBuffered; // Reduced variant buffered mode
  logic redIrq; // Reduced variant interrupt
  logic [15:0] td;
  // Reset table: offset in high byte, value in low byte; 0x40 is unmapped
  logic [15:0] rstTab[14] = '{16'h2300, 16'h2600, 16'h2700, 16'h28ff, 16'h2903, 16'h2a00,
    16'h2b00, 16'h2c00, 16'h2d00, 16'h2e00, 16'h2f00, 16'h3000, 16'h3100, 16'h4000};
  // Window samples: slot in bits 13:10, value below
  logic [13:0] smpTab[5] = '{14'h0601, 14'h0a00, 14'h0fff, 14'h1100, 14'h24ff};

  adc_result_and_window_watch adc_result_and_window_watch_inst (
    .mclk(mclk),
    .rst_b(rst_b),
    .busReq(busReq),
    .rdData(rdData),
    .sample(sample),
    .slotRead(slotRead),
    .slotReadIdx(slotReadIdx),
    .bufferedMode(bufferedMode),
    .toBuffer(toBuffer),
    .schmittDisable(schmittDisable),
    .windowIrq(windowIrq)
  );
  analog_core_model analog_core_model_inst (
    .mclk(mclk),
    .sample(sample),
    .slotRead(slotRead),
    .slotReadIdx(slotReadIdx)
  );
  // Reduced variant shares bus and core; its omitted registers must stay empty
  if (1'b1) begin : gReduced
    adc_result_and_window_watch #(
      .FULL_VARIANT(1'b0)
    ) adc_result_and_window_watch_inst (
      .mclk(mclk),
      .rst_b(rst_b),
      .busReq(busReq),
      .rdData(redRdData),
      .sample(sample),
      .slotRead(slotRead),
      .slotReadIdx(slotReadIdx),
      .bufferedMode(redBuffered),
      .toBuffer(redToBuffer),
      .schmittDisable(),
      .windowIrq(redIrq)
    );
  end

  // ----------------------------------------
  // Clock, compare, verdict, bus tasks
  // ----------------------------------------
  always #25 mclk = ~mclk;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic printVerdict;
    if (errCount == 0 && nChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One-cycle write; a gap edge keeps strobes from being reassigned in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    busReq <= '0;
  endtask
  // One-cycle read; the expectation waits in the queue for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    noteQ.push_back('{exp: e, what: $sformatf("reg %h", a)});
    @(posedge mclk);
    busReq <= '0;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    rdSeen <= busReq.rd;
    rdAddr <= busReq.addr;
    if (rdSeen) begin
      if (rdAddr inside {8'h23, [8'h28:8'h2f]}) begin
        check("reduced reg", {8'h00, redRdData}, 16'h0000);
      end
      if (noteQ.size() == 0) check("read queue", 16'h1, 16'h0);
      else begin
        cur = noteQ.pop_front();
        check(cur.what, {8'h00, rdData}, {8'h00, cur.exp});
      end
    end
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    errCount++;
    printVerdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    busReq = '0;
    errCount = 0;
    nChecks = 0;
    void'($urandom(32'h7df3));
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    // Reset values, unmapped reads zero
    foreach (rstTab[i]) rd(rstTab[i][15:8], rstTab[i][7:0]);
    // Schmitt bits reach the pins
    td = 16'($urandom());
    wr(8'h26, td[15:8]);
    wr(8'h27, td[7:0]);
    @(negedge mclk) check("schmitt pins", schmittDisable, td);
    rd(8'h26, td[15:8]);
    // Left then right layout, each read in its own order
    for (int j = 0; j < 2; j++) begin
      val = 10'($urandom());
      wr(8'h30, {5'h00, j[0], 2'h0});
      analog_core_model_inst.convert(4'h0, val, j + 1);
      if (j == 0) begin
        rd(8'h24, val[9:2]);
        rd(8'h25, {6'h00, val[1:0]});
      end else begin
        rd(8'h25, val[7:0]);
        rd(8'h24, {6'h00, val[9:8]});
      end
    end
    // Result register ignores writes
    wr(8'h24, ~{6'h00, val[9:8]});
    rd(8'h24, {6'h00, val[9:8]});
    // Buffer enable alone, then with continuous
    wr(8'h23, 8'h80);
    @(negedge mclk) check("buffer modes", {toBuffer, bufferedMode}, 2'b10);
    wr(8'h30, 8'h05);
    @(negedge mclk) check("buffer modes", {toBuffer, bufferedMode}, 2'b11);
    analog_core_model_inst.convert(4'h0, ~val, 3);
    rd(8'h24, {6'h00, val[9:8]});
    // Window 0x100..0x200, slot 3 unchecked
    wr(8'h28, 8'h80);
    wr(8'h29, 8'h00);
    wr(8'h2a, 8'h40);
    wr(8'h2b, 8'h00);
    wr(8'h2e, 8'h03);
    wr(8'h2f, 8'hf7);
    rd(8'h28, 8'h80);
    rd(8'h2a, 8'h40);
    foreach (smpTab[i]) analog_core_model_inst.convert(smpTab[i][13:10], smpTab[i][9:0], 1);
    rd(8'h2c, 8'h02);
    rd(8'h2d, 8'h02);
    rd(8'h31, 8'h01);
    @(negedge mclk) check("irq masked", {15'h0, windowIrq}, 16'h0);
    wr(8'h30, 8'h0d);
    @(negedge mclk) check("irq raised", {15'h0, windowIrq}, 16'h1);
    check("reduced modes", {13'h0000, redToBuffer, redBuffered, redIrq}, 16'h0000);
    // Flags clear by writing zero
    wr(8'h2d, 8'hfd);
    wr(8'h2c, 8'h00);
    rd(8'h2d, 8'h00);
    rd(8'h2c, 8'h00);
    wr(8'h31, 8'h00);
    @(negedge mclk) check("irq cleared", {15'h0, windowIrq}, 16'h0);
    // Overwrite after a fetch is clean; without one it overruns
    analog_core_model_inst.convert(4'h5, 10'h180, 1);
    analog_core_model_inst.fetch(4'h5);
    analog_core_model_inst.convert(4'h5, 10'h181, 2);
    rd(8'h23, 8'h80);
    analog_core_model_inst.convert(4'h5, 10'h182, 1);
    rd(8'h23, 8'hc0);
    wr(8'h23, 8'h80);
    rd(8'h23, 8'h80);
    repeat (3) @(posedge mclk);
    printVerdict();
  end
endmodule
`default_nettype wire
